// ### rtl/charge_core.v
// Overview of operation
// - two-step voltage: termination level is fast current /10, /20, /30 for low, high, float.
// - two-step current: maintenance average is fast current /10, /20, /40.
// - two-step voltage: fast charge ends when current falls to termination level.
// - sense below 0.4 of supply is over-temperature cut-off; no charging.
// - after cut-off, charging stays inhibited until sense rises above 0.44.
// - sense above 0.6 of supply is too cold; no charging while it holds.
// - every interval except the time-out is a fixed fraction of the time-out.
// - first qualification test limited to 0.02 of the time-out.
// - second qualification test limited to 0.16 of the time-out.
// - second-difference voltage sampled every 0.008 of the time-out.
// - hold-off of 0.002 of the time-out at start of second test.
// - hold-off of 0.015 of the time-out at start of bulk charging.
// - time-out programmable from 1 hour to 24 hours.
// - voltage and current modulators share one sawtooth ramp.
// - switch drive is constant frequency, aligned to ramp periods.
// - drive held inactive in ramp-down, about 20 percent, so duty never exceeds 80 percent.
// - time-out expiry before termination drives switch low and enters fault.
// - during hold-off only battery cut-off limits act, no voltage termination.
// - temperature out of range: pending, switch low, timers frozen, resumed not reset.
//
// Local design decisions: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "charge_ctl_regs.vh"
module charge_core #(
  parameter CLK_HZ       = 20000000,
  parameter UNIT_CYCLES  = 1200000,
  parameter DEB_CYCLES   = 16,
  parameter RAMP_PERIOD  = 200,
  parameter RAMP_DOWN_PC = 20
) (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_reset_n,
  // avalon-mm slave
  input  wire [4:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // comparator pins
  input  wire        i_min_current_select_low,
  input  wire        i_min_current_select_high,
  input  wire        i_temp_cutoff_limit,
  input  wire        i_high_temp_release,
  input  wire        i_low_temp_limit,
  input  wire        i_vbat_out_of_range,
  input  wire        i_qual1_pass,
  input  wire        i_qual2_pass,
  input  wire        i_voltage_term,
  input  wire        i_current_at_min,
  // loop control levels from same-clock converters
  input  wire [7:0]  i_vloop_level,
  input  wire [7:0]  i_iloop_level,
  // outputs
  output wire        o_switch_drive_output,
  output wire [5:0]  o_termination_current_level,
  output wire        o_charge_pending,
  output wire        o_fault
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_QUAL1 = 3'h1;
  localparam ST_QUAL2 = 3'h2;
  localparam ST_FAST  = 3'h3;
  localparam ST_MAINT = 3'h4;
  localparam ST_FAULT = 3'h5;
  localparam [7:0] RAMP_LAST = RAMP_PERIOD - 1;
  localparam [7:0] RAMP_UP   = RAMP_PERIOD - (RAMP_PERIOD * RAMP_DOWN_PC) / 100;

  function [5:0] term_div;
    input [1:0] alg;
    input [1:0] sel;
    begin
      case (sel)
        `CC_SEL_LOW:  term_div = `CC_DIV_LOW;
        `CC_SEL_HIGH: term_div = `CC_DIV_HIGH;
        default:      term_div = (alg == `CC_ALG_TWO_CURR) ? `CC_DIV_FLT_CURR : `CC_DIV_FLT_VOLT;
      endcase
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  be;
    begin
      merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
    end
  endfunction

  // reset release through two flops
  reg rst_s1_reg;
  reg rst_n;
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // pin conditioning
  wire [`CC_NPIN-1:0] pin_raw;
  wire [`CC_NPIN-1:0] pin;
  assign pin_raw = {i_current_at_min, i_voltage_term, i_qual2_pass, i_qual1_pass,
                    i_vbat_out_of_range, i_low_temp_limit, i_high_temp_release,
                    i_temp_cutoff_limit, i_min_current_select_high, i_min_current_select_low};
  genvar g;
  generate
    for (g = 0; g < `CC_NPIN; g = g + 1) begin : g_pin
      pin_debounce #(
        .DEB_CYCLES (DEB_CYCLES)
      ) u_deb (
        .i_mclk  (i_mclk),
        .i_rst_n (rst_n),
        .i_pin   (pin_raw[g]),
        .o_level (pin[g])
      );
    end
  endgenerate

  // registers
  reg [2:0]  ctrl_reg;
  reg [10:0] timeout_reg;
  reg        ack_reg;
  reg [31:0] rdata_reg;
  wire       enable;
  wire [1:0] alg;
  wire       req;
  wire [15:0] to_new;
  reg  [10:0] to_clamped;
  assign enable = ctrl_reg[`CC_CTRL_EN_BIT];
  assign alg    = ctrl_reg[`CC_CTRL_ALG_MSB:`CC_CTRL_ALG_LSB];
  assign req    = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_reg;
  assign o_avs_readdata    = rdata_reg;
  assign to_new = merge16({5'h00, timeout_reg}, i_avs_writedata[15:0], i_avs_byteenable[1:0]);

  always @* begin
    if (to_new > {5'h00, `CC_TIMEOUT_MAX}) begin
      to_clamped = `CC_TIMEOUT_MAX;
    end else if (to_new < {5'h00, `CC_TIMEOUT_MIN}) begin
      to_clamped = `CC_TIMEOUT_MIN;
    end else begin
      to_clamped = to_new[10:0];
    end
  end

  // state and status
  reg [2:0]  state_reg;
  reg [10:0] phase_reg;
  reg [10:0] mto_reg;
  reg [2:0]  dv_reg;
  reg        cut_latch_reg;
  reg [1:0]  sel_reg;
  reg [5:0]  div_reg;
  wire       pending;
  wire       holdoff;
  wire [31:0] status_word;
  assign pending = cut_latch_reg | pin[`CC_PIN_TS_LOW];
  assign status_word = {20'h00000, sel_reg, holdoff, pin[`CC_PIN_TS_LOW], cut_latch_reg,
                        pending, 3'h0, state_reg};

  // single wait cycle: data registered, answer on the second edge
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg     <= 1'b0;
      rdata_reg   <= 32'h00000000;
      ctrl_reg    <= `CC_CTRL_RST;
      timeout_reg <= `CC_TIMEOUT_RST;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (i_avs_read & ~ack_reg) begin
        case (i_avs_address)
          `CC_ADDR_CTRL:    rdata_reg <= {29'h00000000, ctrl_reg};
          `CC_ADDR_TIMEOUT: rdata_reg <= {21'h000000, timeout_reg};
          `CC_ADDR_STATUS:  rdata_reg <= status_word;
          `CC_ADDR_TERM:    rdata_reg <= {26'h0000000, div_reg};
          `CC_ADDR_ELAPSED: rdata_reg <= {21'h000000, mto_reg};
          default:          rdata_reg <= 32'h00000000;
        endcase
      end
      if (i_avs_write & ack_reg) begin
        if (i_avs_address == `CC_ADDR_CTRL && i_avs_byteenable[0]) begin
          ctrl_reg <= i_avs_writedata[2:0];
        end
        if (i_avs_address == `CC_ADDR_TIMEOUT) begin
          timeout_reg <= to_clamped;
        end
      end
    end
  end

  // temperature window with hysteresis on the hot side
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      cut_latch_reg <= 1'b0;
    end else if (pin[`CC_PIN_TS_CUT]) begin
      cut_latch_reg <= 1'b1;
    end else if (pin[`CC_PIN_TS_REL]) begin
      cut_latch_reg <= 1'b0;
    end
  end

  // termination level; both select comparators high reads as low
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= `CC_SEL_FLOAT;
      div_reg <= `CC_DIV_LOW;
    end else begin
      if (pin[`CC_PIN_SEL_LOW]) begin
        sel_reg <= `CC_SEL_LOW;
      end else if (pin[`CC_PIN_SEL_HIGH]) begin
        sel_reg <= `CC_SEL_HIGH;
      end else begin
        sel_reg <= `CC_SEL_FLOAT;
      end
      div_reg <= term_div(alg, sel_reg);
    end
  end
  assign o_termination_current_level = div_reg;

  // timebase: unit = 1/1000 minute, thousandth tick = timeout/1000
  reg  [31:0] pre_reg;
  reg  [10:0] sub_reg;
  wire        unit_en;
  wire        pm_tick;
  wire        timing;
  assign timing  = ~pending & (state_reg != ST_IDLE) & (state_reg != ST_FAULT)
                   & (state_reg != ST_MAINT);
  assign unit_en = timing & (pre_reg == UNIT_CYCLES - 1);
  assign pm_tick = unit_en & (sub_reg == timeout_reg - 11'h001);

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 32'h00000000;
      sub_reg <= 11'h000;
    end else if (timing) begin
      if (unit_en) begin
        pre_reg <= 32'h00000000;
        sub_reg <= pm_tick ? 11'h000 : sub_reg + 11'h001;
      end else begin
        pre_reg <= pre_reg + 32'h00000001;
      end
    end
  end

  // charge sequence
  reg  [2:0]  state_next;
  reg         clr_phase;
  reg         clr_mto;
  wire        dv_tick;
  assign holdoff = (state_reg == ST_QUAL2 && phase_reg < `CC_HO1_PM)
                 | (state_reg == ST_FAST && phase_reg < `CC_HO2_PM);
  assign dv_tick = pm_tick & (dv_reg == `CC_DV_PM - 3'h1);

  always @* begin
    state_next = state_reg;
    clr_phase  = 1'b0;
    clr_mto    = 1'b0;
    if (!enable) begin
      state_next = ST_IDLE;
    end else if (pending) begin
      state_next = state_reg;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_QUAL1;
          clr_phase  = 1'b1;
          clr_mto    = 1'b1;
        end
        ST_QUAL1: begin
          if (pin[`CC_PIN_VBAT_OUT]) begin
            state_next = ST_FAULT;
          end else if (pin[`CC_PIN_QUAL1]) begin
            state_next = ST_QUAL2;
            clr_phase  = 1'b1;
          end else if (phase_reg >= `CC_QT1_PM) begin
            state_next = ST_FAULT;
          end
        end
        ST_QUAL2: begin
          if (pin[`CC_PIN_VBAT_OUT]) begin
            state_next = ST_FAULT;
          end else if (!holdoff && pin[`CC_PIN_QUAL2]) begin
            state_next = ST_FAST;
            clr_phase  = 1'b1;
            clr_mto    = 1'b1;
          end else if (phase_reg >= `CC_QT2_PM) begin
            state_next = ST_FAULT;
          end
        end
        ST_FAST: begin
          if (pin[`CC_PIN_VBAT_OUT]) begin
            state_next = ST_FAULT;
          end else if (mto_reg >= `CC_MTO_PM) begin
            state_next = ST_FAULT;
          end else if (holdoff) begin
            state_next = ST_FAST;
          end else if (alg == `CC_ALG_TWO_VOLT && pin[`CC_PIN_CUR_MIN]) begin
            state_next = ST_MAINT;
          end else if (dv_tick && pin[`CC_PIN_VTERM]) begin
            state_next = ST_MAINT;
          end
        end
        ST_MAINT: begin
          if (pin[`CC_PIN_VBAT_OUT]) begin
            state_next = ST_FAULT;
          end
        end
        ST_FAULT: begin
          state_next = ST_FAULT;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // counters freeze, not clear, while pending
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      phase_reg <= 11'h000;
      mto_reg   <= 11'h000;
      dv_reg    <= 3'h0;
    end else begin
      state_reg <= state_next;
      if (clr_phase) begin
        phase_reg <= 11'h000;
        dv_reg    <= 3'h0;
      end else if (pm_tick) begin
        phase_reg <= (phase_reg == 11'h7FF) ? phase_reg : phase_reg + 11'h001;
        dv_reg    <= dv_tick ? 3'h0 : dv_reg + 3'h1;
      end
      if (clr_mto) begin
        mto_reg <= 11'h000;
      end else if (pm_tick && mto_reg != 11'h7FF) begin
        mto_reg <= mto_reg + 11'h001;
      end
    end
  end

  // shared ramp, one period per switching cycle
  reg  [7:0] ramp_reg;
  reg        drive_reg;
  wire       charging;
  wire       v_on;
  wire       i_on;
  assign charging = ~pending & (state_reg == ST_QUAL1 || state_reg == ST_QUAL2
                    || state_reg == ST_FAST || state_reg == ST_MAINT);
  assign v_on = ramp_reg < i_vloop_level;
  assign i_on = ramp_reg < i_iloop_level;

  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_reg  <= 8'h00;
      drive_reg <= 1'b0;
    end else begin
      ramp_reg  <= (ramp_reg == RAMP_LAST) ? 8'h00 : ramp_reg + 8'h01;
      // pulse may start only at ramp zero, so a late enable never makes a short period
      drive_reg <= charging & v_on & i_on & (ramp_reg < RAMP_UP) & (drive_reg | (ramp_reg == 8'h00));
    end
  end

  assign o_switch_drive_output = drive_reg;
  assign o_charge_pending      = pending;
  assign o_fault               = (state_reg == ST_FAULT);
endmodule // charge_core

// ### common/charge_ctl_regs.vh
`ifndef CHARGE_CTL_REGS_VH
`define CHARGE_CTL_REGS_VH

// byte addresses on the register bus
`define CC_ADDR_CTRL      5'h00
`define CC_ADDR_TIMEOUT   5'h04
`define CC_ADDR_STATUS    5'h08
`define CC_ADDR_TERM      5'h0C
`define CC_ADDR_ELAPSED   5'h10

// control fields
`define CC_CTRL_EN_BIT    0
`define CC_CTRL_ALG_LSB   1
`define CC_CTRL_ALG_MSB   2
`define CC_CTRL_RST       3'h0

// charge algorithms
`define CC_ALG_TWO_VOLT   2'h0
`define CC_ALG_TWO_CURR   2'h1
`define CC_ALG_PULSED     2'h2

// time-out in minutes, 1 h to 24 h
`define CC_TIMEOUT_RST    11'h12C
`define CC_TIMEOUT_MIN    11'h03C
`define CC_TIMEOUT_MAX    11'h5A0

// intervals in thousandths of the time-out
`define CC_MTO_PM         11'h3E8
`define CC_QT1_PM         11'h014
`define CC_QT2_PM         11'h0A0
`define CC_DV_PM          11'h008
`define CC_HO1_PM         11'h002
`define CC_HO2_PM         11'h00F

// termination current divisors of the fast-charge current
`define CC_DIV_LOW        6'h0A
`define CC_DIV_HIGH       6'h14
`define CC_DIV_FLT_VOLT   6'h1E
`define CC_DIV_FLT_CURR   6'h28

// select input codes
`define CC_SEL_LOW        2'h0
`define CC_SEL_HIGH       2'h1
`define CC_SEL_FLOAT      2'h2

// synchronised pin indices
`define CC_PIN_SEL_LOW    0
`define CC_PIN_SEL_HIGH   1
`define CC_PIN_TS_CUT     2
`define CC_PIN_TS_REL     3
`define CC_PIN_TS_LOW     4
`define CC_PIN_VBAT_OUT   5
`define CC_PIN_QUAL1      6
`define CC_PIN_QUAL2      7
`define CC_PIN_VTERM      8
`define CC_PIN_CUR_MIN    9
`define CC_NPIN           10

`endif

// ### rtl/pin_debounce.v
`timescale 1ns/1ps
module pin_debounce #(
  parameter DEB_CYCLES = 16
) (
  // clock and reset
  input  wire i_mclk,
  input  wire i_rst_n,
  // pin and clean level
  input  wire i_pin,
  output wire o_level
);
  localparam [15:0] DEB_LAST = DEB_CYCLES - 1;
  reg [2:0]  sync_reg;
  reg [15:0] cnt_reg;
  reg        level_reg;

  assign o_level = level_reg;

  // first stage feeds only the second; stages two and three must agree
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_reg  <= 3'h0;
      cnt_reg   <= 16'h0000;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], i_pin};
      if (sync_reg[1] != sync_reg[2] || sync_reg[2] == level_reg) begin
        cnt_reg <= 16'h0000;
      end else if (cnt_reg == DEB_LAST) begin
        cnt_reg   <= 16'h0000;
        level_reg <= sync_reg[2];
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end
endmodule // pin_debounce

// ### tb/charge_plant.sv
`timescale 1ns/1ps
module charge_plant (
  // sense level in thousandths of supply, select strap
  input  wire [9:0] i_ts_milli,
  input  wire [1:0] i_sel_mode,
  // comparator outputs
  output wire       o_sel_low,
  output wire       o_sel_high,
  output wire       o_cutoff,
  output wire       o_release,
  output wire       o_cold
);
  // float strap: both comparators idle
  assign o_sel_low  = (i_sel_mode == 2'h0);
  assign o_sel_high = (i_sel_mode == 2'h1);
  assign o_cutoff   = (i_ts_milli < 10'h190);
  assign o_release  = (i_ts_milli > 10'h1B8);
  assign o_cold     = (i_ts_milli > 10'h258);
endmodule  // charge_plant

// ### tb/charge_core_props.sv
`timescale 1ns/1ps
module charge_core_props #(
  parameter DEB_CYCLES   = 16,
  parameter RAMP_PERIOD  = 200,
  parameter RAMP_DOWN_PC = 20
) (
  // clock, reset, bus
  input wire       i_mclk,
  input wire       i_reset_n,
  input wire       i_avs_read,
  input wire       i_avs_write,
  input wire       o_avs_waitrequest,
  // pins
  input wire       i_temp_cutoff_limit,
  input wire       i_low_temp_limit,
  input wire       o_switch_drive_output,
  input wire [5:0] o_termination_current_level,
  input wire       o_charge_pending,
  input wire       o_fault
);
  localparam int HI_MAX = RAMP_PERIOD * (100 - RAMP_DOWN_PC) / 100;
  logic [10:0] hi_cnt, gap_cnt, bad_cnt;
  logic        drv_q, seen;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hi_cnt <= 11'h000;
      gap_cnt <= 11'h000;
      bad_cnt <= 11'h000;
      drv_q <= 1'b0;
      seen <= 1'b0;
    end else begin
      drv_q <= o_switch_drive_output;
      hi_cnt <= o_switch_drive_output ? hi_cnt + 11'h001 : 11'h000;
      // saturate so long idle gaps never wrap
      if (o_switch_drive_output && !drv_q) begin
        gap_cnt <= 11'h001;
        seen <= 1'b1;
      end else if (gap_cnt != 11'h7FF) begin
        gap_cnt <= gap_cnt + 11'h001;
      end
      if (!(i_temp_cutoff_limit || i_low_temp_limit))
        bad_cnt <= 11'h000;
      else if (bad_cnt != 11'h7FF)
        bad_cnt <= bad_cnt + 11'h001;
    end
  end
  a_wait_one_cycle: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held beyond one cycle");
  a_duty_limit: assert property (hi_cnt <= HI_MAX)
    else $error("drive high past ramp-down start");
  a_ramp_aligned: assert property ($rose(o_switch_drive_output) && seen && gap_cnt < 2 * RAMP_PERIOD
    |-> gap_cnt == RAMP_PERIOD) else $error("drive period not aligned to ramp");
  a_term_codes: assert property (o_termination_current_level inside {6'h0A, 6'h14, 6'h1E, 6'h28})
    else $error("termination divisor outside table");
  a_fault_drive_low: assert property (o_fault && $past(o_fault) |-> !o_switch_drive_output)
    else $error("drive active in fault");
  a_pending_drive_low: assert property (o_charge_pending && $past(o_charge_pending) |-> !o_switch_drive_output)
    else $error("drive active while pending");
  a_temp_debounced: assert property ($rose(o_charge_pending) |-> bad_cnt >= DEB_CYCLES)
    else $error("pending raised before debounce");
  a_fault_exit_write: assert property ($fell(o_fault)
    |-> $past(i_avs_write) || $past(i_avs_write, 2) || $past(i_avs_write, 3)) else $error("fault left without write");
  c_fault: cover property ($rose(o_fault));
  c_pending: cover property ($rose(o_charge_pending));
  c_period: cover property ($rose(o_switch_drive_output) && seen && gap_cnt == RAMP_PERIOD);
endmodule  // charge_core_props
bind charge_core charge_core_props #(.DEB_CYCLES(DEB_CYCLES), .RAMP_PERIOD(RAMP_PERIOD),
  .RAMP_DOWN_PC(RAMP_DOWN_PC)) u_props (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .i_temp_cutoff_limit(i_temp_cutoff_limit),
  .i_low_temp_limit(i_low_temp_limit), .o_switch_drive_output(o_switch_drive_output),
  .o_termination_current_level(o_termination_current_level), .o_charge_pending(o_charge_pending),
  .o_fault(o_fault));

// ### tb/charge_core_tb.sv
`timescale 1ns/1ps
`include "charge_ctl_regs.vh"
module charge_core_tb;
  logic        i_mclk, i_reset_n, rd, wr, q1, q2, vterm, curmin;
  logic [4:0]  addr;
  logic [31:0] wdata, q, e1, e2;
  logic [7:0]  vlev, ilev;
  logic [9:0]  ts;
  logic [1:0]  sel;
  wire  [31:0] rdata;
  wire  [5:0]  term;
  wire         waitreq, drv, pend, fault, s_lo, s_hi, cut, rel, cold;
  int          mismatches, comparisons, n;
  charge_plant plant (.i_ts_milli(ts), .i_sel_mode(sel), .o_sel_low(s_lo), .o_sel_high(s_hi),
    .o_cutoff(cut), .o_release(rel), .o_cold(cold));
  // one unit cycle keeps the 60 minute time-out at 60000 clocks
  charge_core #(.UNIT_CYCLES(1), .DEB_CYCLES(2)) uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_min_current_select_low(s_lo), .i_min_current_select_high(s_hi), .i_temp_cutoff_limit(cut),
    .i_high_temp_release(rel), .i_low_temp_limit(cold), .i_vbat_out_of_range(1'b0), .i_qual1_pass(q1),
    .i_qual2_pass(q2), .i_voltage_term(vterm), .i_current_at_min(curmin), .i_vloop_level(vlev),
    .i_iloop_level(ilev), .o_switch_drive_output(drv), .o_termination_current_level(term),
    .o_charge_pending(pend), .o_fault(fault));
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  task automatic close_out();
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input [31:0] exp, input [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic bus(input bit w, input [4:0] a, input [31:0] d);
    int k;
    k = 0;
    @(posedge i_mclk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    // waitrequest and read data as the slave shows them at this edge
    do begin
      @(posedge i_mclk);
      k++;
      if (k > 50) begin
        mismatches++;
        close_out();
      end
    end while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input string name, input [4:0] a, input [31:0] exp);
    bus(0, a, 32'h0);
    chk(name, exp, q);
  endtask
  task automatic st(input [2:0] e);
    bus(0, `CC_ADDR_STATUS, 32'h0);
    chk("state", {29'h0, e}, {29'h0, q[2:0]});
  endtask
  task automatic wait_st(input [2:0] e, input int bound);
    int k;
    k = 0;
    q = 32'h0;
    while (q[2:0] !== e && k < bound) begin
      bus(0, `CC_ADDR_STATUS, 32'h0);
      k++;
    end
    chk("state wait", {29'h0, e}, {29'h0, q[2:0]});
    if (q[2:0] !== e)
      close_out();
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_mclk);
  endtask
  task automatic duty(input [31:0] exp);
    n = 0;
    repeat (200) begin
      @(negedge i_mclk);
      n += drv;
    end
    chk("duty", exp, n);
    @(posedge i_mclk);
  endtask
  initial begin
    {i_reset_n, rd, wr, q1, q2, vterm, curmin} = 7'h00;
    {addr, wdata, sel, vlev, ilev} = {5'h00, 32'h0, 2'h0, 8'h40, 8'h40};
    ts = 10'h1F4;
    mismatches = 0;
    comparisons = 0;
    idle(16);
    chk("reset outputs", 32'h00A, {drv, pend, fault, term});
    i_reset_n <= 1'b1;
    idle(3);
    rdc("ctrl", `CC_ADDR_CTRL, 32'h0);
    rdc("timeout", `CC_ADDR_TIMEOUT, 32'h12C);
    bus(1, `CC_ADDR_TIMEOUT, 32'h1);
    rdc("timeout low", `CC_ADDR_TIMEOUT, 32'h3C);
    bus(1, `CC_ADDR_TIMEOUT, 32'h7FF);
    rdc("timeout high", `CC_ADDR_TIMEOUT, 32'h5A0);
    bus(1, 5'h14, 32'hFFFF);
    rdc("unmapped", 5'h14, 32'h0);
    bus(1, `CC_ADDR_TIMEOUT, 32'h3C);
    for (int a = 0; a < 2; a++) begin
      for (int s = 0; s < 3; s++) begin
        sel <= s[1:0];
        bus(1, `CC_ADDR_CTRL, a << 1);
        idle(20);
        e1 = (s == 0) ? 32'hA : (s == 1) ? 32'h14 : (a == 0) ? 32'h1E : 32'h28;
        chk("term pin", e1, term);
        rdc("term reg", `CC_ADDR_TERM, e1);
      end
    end
    bus(1, `CC_ADDR_CTRL, 32'h1);
    idle(1100);
    st(1);
    idle(250);
    st(5);
    chk("fault drive", 32'h2, {fault, drv});
    bus(1, `CC_ADDR_CTRL, 32'h0);
    st(0);
    q1 <= 1'b1;
    q2 <= 1'b1;
    bus(1, `CC_ADDR_CTRL, 32'h1);
    idle(30);
    st(2);
    wait_st(3, 100);
    bus(1, `CC_ADDR_CTRL, 32'h0);
    q2 <= 1'b0;
    bus(1, `CC_ADDR_CTRL, 32'h1);
    idle(9300);
    st(2);
    idle(600);
    st(5);
    bus(1, `CC_ADDR_CTRL, 32'h0);
    q2 <= 1'b1;
    vterm <= 1'b1;
    bus(1, `CC_ADDR_CTRL, 32'h3);
    wait_st(3, 150);
    idle(600);
    st(3);
    idle(600);
    st(4);
    bus(1, `CC_ADDR_CTRL, 32'h0);
    vterm <= 1'b0;
    bus(1, `CC_ADDR_CTRL, 32'h1);
    wait_st(3, 150);
    idle(1000);
    st(3);
    ts <= 10'h2BC;
    idle(20);
    chk("cold pending", 32'h2, {pend, drv});
    bus(0, `CC_ADDR_ELAPSED, 32'h0);
    e1 = q;
    idle(300);
    rdc("elapsed frozen", `CC_ADDR_ELAPSED, e1);
    ts <= 10'h1F4;
    idle(20);
    chk("cold cleared", 32'h0, pend);
    idle(300);
    bus(0, `CC_ADDR_ELAPSED, 32'h0);
    chk("elapsed resumed", 32'h1, q > e1);
    st(3);
    ts <= 10'h15E;
    idle(20);
    chk("cutoff", 32'h1, pend);
    ts <= 10'h1A4;
    idle(20);
    chk("cutoff held", 32'h1, pend);
    ts <= 10'h1F4;
    idle(20);
    chk("cutoff released", 32'h0, pend);
    vlev <= 8'h32;
    ilev <= 8'h5A;
    idle(400);
    duty(32'h32);
    vlev <= 8'hFF;
    ilev <= 8'hC8;
    idle(400);
    duty(32'hA0);
    wait_st(5, 25000);
    chk("timeout drive", 32'h0, drv);
    bus(1, `CC_ADDR_CTRL, 32'h0);
    bus(1, `CC_ADDR_CTRL, 32'h1);
    wait_st(3, 150);
    curmin <= 1'b1;
    wait_st(4, 400);
    close_out();
  end
endmodule  // charge_core_tb
